// ==== dv/reader_result_input_framer_bench.sv ====
`default_nettype none
module reader_result_input_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic accept = 1'b1;
  logic stall = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq, byte_strobe, frame_done;
  logic [7:0] frame_inst, hdr_status, hdr_count, hdr_flags, byte_data;
  logic [8:0] frame_len, res_len, byte_idx;
  logic [7:0] cap [0:263];
  int fail_count = 0;
  int n_tests = 0;
  rrif_link_if link ();
  rrif_reader_end rrif_reader_end_inst (.ref_clk, .resetn, .link, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  rrif_ctl_end rrif_ctl_end_inst (.ref_clk, .resetn, .link, .accept, .frame_inst, .frame_len,
    .hdr_status, .hdr_count, .hdr_flags, .res_len, .byte_data, .byte_idx, .byte_strobe,
    .frame_done);
  rrif_checker rrif_checker_inst (.ref_clk, .resetn, .sof(link.sof), .valid(link.valid),
    .last(link.last), .data(link.data), .inst(link.inst), .ready(link.ready));
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) accept <= !stall || !accept;
  always @(posedge ref_clk) if (byte_strobe) cap[byte_idx] <= byte_data;
  task report_and_stop;
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic rnw, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rnw;
    avs_write <= !rnw;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      chk("bus", 0, 1);
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask
  task wait_ev(input int n, input logic for_irq);
    int i;
    for (i = 0; n > 0 && i < 3000; i++) begin
      @(posedge ref_clk);
      if ((for_irq ? irq : frame_done) === 1'b1) n--;
    end
    if (n > 0) begin
      chk("wait", 0, 1);
      report_and_stop();
    end
  endtask
  task load(input logic [31:0] ctrl, input logic [31:0] len, input logic [31:0] h, input int n);
    bus(0, rrif_pkg::REG_CTRL, 32'h100);
    bus(0, rrif_pkg::REG_HDR, h);
    bus(0, rrif_pkg::REG_LEN, len);
    for (int k = 0; k < n; k++) bus(0, rrif_pkg::REG_DATA, 32'(8'(k + 48)));
    bus(0, rrif_pkg::REG_CTRL, ctrl);
    wait_ev(2, 0);
    @(posedge ref_clk);
  endtask
  task t_plain;
    stall <= 1'b1;
    load(32'h1, 32'h8, 32'h0015_02A5, 3);
    stall <= 1'b0;
    chk("inst", rrif_pkg::INST_PLAIN, frame_inst);
    chk("len", 32'h8, frame_len);
    chk("hdr", 32'h1502A5, {hdr_flags, hdr_count, hdr_status});
    chk("plen", 32'h0003, {cap[4], cap[3]});
    chk("pay", 32'h3230, {cap[7], cap[5]});
  endtask
  task t_frag;
    bus(0, rrif_pkg::REG_FRAG, 32'h0004_0201);
    bus(1, rrif_pkg::REG_FRAG, 0);
    chk("fragrd", 32'h0004_0201, rd);
    load(32'h3, 32'hA, 32'h253F_0703, 1);
    chk("inst", rrif_pkg::INST_FRAG, frame_inst);
    chk("len", 32'hA, frame_len);
    chk("frag", 32'h04020152, {cap[4], cap[3], cap[2], cap[1]});
    chk("hdr", 32'h3F0703, {hdr_flags, hdr_count, hdr_status});
    chk("pay", 32'h130, {res_len[7:0], cap[9]});
  endtask
  task t_limits;
    bus(0, rrif_pkg::REG_MASK, 32'h2);
    load(32'h1, 32'h104, 32'h0, 255);
    chk("len", 32'h104, frame_len);
    chk("tail", 32'h2E, cap[259]);
    chk("masked", 0, irq);
    bus(0, rrif_pkg::REG_LEN, 32'h105);
    bus(1, rrif_pkg::REG_LEN, 0);
    chk("lenrd", 32'h105, rd);
    wait_ev(1, 1);
    bus(0, rrif_pkg::REG_CTRL, 32'h0);
    bus(1, rrif_pkg::REG_IRQ, 0);
    chk("irq", 32'h3, rd[1:0]);
    bus(1, rrif_pkg::REG_IRQ, 0);
    chk("clr", 32'h0, {irq, rd[1:0]});
    bus(1, 4'hF, 0);
    chk("unmap", rrif_pkg::RDATA_BAD, rd);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    t_plain();
    t_frag();
    t_limits();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== dv/rrif_checker.sv ====
`default_nettype none
module rrif_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sof,
  input wire logic valid,
  input wire logic last,
  input wire logic [7:0] data,
  input wire logic [7:0] inst,
  input wire logic ready
);
  logic [8:0] cnt_reg;
  logic [15:0] plen_reg;
  wire take = valid && ready;
  wire frag = inst == rrif_pkg::INST_FRAG;
  wire [8:0] hdr = frag ? rrif_pkg::FRAG_HDR : rrif_pkg::PLAIN_HDR;
  always_ff @(posedge ref_clk) begin
    if (!resetn) cnt_reg <= 9'h000;
    else if (take) cnt_reg <= last ? 9'h000 : cnt_reg + 9'h001;
  end
  // Payload length field as sent
  always_ff @(posedge ref_clk) begin
    if (take && cnt_reg == hdr - 9'h002) plen_reg[7:0] <= data;
    if (take && cnt_reg == hdr - 9'h001) plen_reg[15:8] <= data;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence idle_two; !valid [*2]; endsequence
  inst_legal_a: assert property (valid |-> inst == rrif_pkg::INST_PLAIN || frag)
    else $error("bad instance");
  sof_first_a: assert property (valid |-> sof == (cnt_reg == 9'h000))
    else $error("sof misplaced");
  stall_hold_a: assert property (valid && !ready |=>
    valid && $stable(data) && $stable(last))
    else $error("byte dropped in stall");
  frame_gap_a: assert property (take && last |=> idle_two)
    else $error("no gap");
  plain_max_a: assert property (valid && !frag |-> cnt_reg < rrif_pkg::PLAIN_LEN_MAX)
    else $error("plain too long");
  frag_max_a: assert property (valid && frag |-> cnt_reg < rrif_pkg::FRAG_LEN_MAX)
    else $error("frag too long");
  inst_hold_a: assert property (valid && !sof |-> $stable(inst))
    else $error("instance changed");
  payload_end_a: assert property (take && last && cnt_reg >= hdr |->
    cnt_reg == hdr + plen_reg[8:0] - 9'h001)
    else $error("payload count");
endmodule
`default_nettype wire

// ==== pkg/rrif_link_if.sv ====
`default_nettype none
interface rrif_link_if;
  logic sof;
  logic valid;
  logic last;
  logic [7:0] data;
  logic [7:0] inst;
  logic ready;
  modport dev (output sof, output valid, output last, output data, output inst, input ready);
  modport ctl (input sof, input valid, input last, input data, input inst, output ready);
endinterface
`default_nettype wire

// ==== pkg/rrif_pkg.sv ====
// Operation
// - Device sends input frames cyclically toward controller
// - Plain frame is instance 100, attribute 3
// - Plain frame length between 1 and 260
// - Plain payload starts at byte 5
// - Controller sets plain length 5 plus result
// - Fragmented frame is instance 101, attribute 3
// - Fragmented frame length between 1 and 264
// - Fragmented payload starts at byte 9
// - Controller sets fragmented length 9 plus result
`default_nettype none
package rrif_pkg;
  localparam logic [7:0] INST_PLAIN = 8'h64;
  localparam logic [7:0] INST_FRAG = 8'h65;
  localparam logic [7:0] ASM_ATTR = 8'h03;
  localparam logic [8:0] LEN_MIN = 9'h001;
  localparam logic [8:0] PLAIN_LEN_MAX = 9'h104;
  localparam logic [8:0] FRAG_LEN_MAX = 9'h108;
  localparam logic [8:0] PLAIN_HDR = 9'h005;
  localparam logic [8:0] FRAG_HDR = 9'h009;
  localparam int PAYLOAD_DEPTH = 255;
  // Avalon register offsets (word index), byte address = 4 * index
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LEN = 4'h1;
  localparam logic [3:0] REG_HDR = 4'h2;
  localparam logic [3:0] REG_FRAG = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ = 4'h6;
  localparam logic [3:0] REG_MASK = 4'h7;
  localparam logic [3:0] REG_RX = 4'h8;
  localparam logic [3:0] REG_RXHDR = 4'h9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_BAD = 32'hDEAD_0000;
  // Sticky event bits
  localparam int EV_SENT = 0;
  localparam int EV_LENERR = 1;
  localparam int EV_RXDONE = 2;
  localparam int EV_W = 3;
endpackage
`default_nettype wire

// ==== src/rrif_ctl_end.sv ====
`default_nettype none
module rrif_ctl_end (
  input wire logic ref_clk,
  input wire logic resetn,
  rrif_link_if.ctl link,
  input wire logic accept,
  output logic [7:0] frame_inst,
  output logic [8:0] frame_len,
  output logic [7:0] hdr_status,
  output logic [7:0] hdr_count,
  output logic [7:0] hdr_flags,
  output logic [8:0] res_len,
  output logic [7:0] byte_data,
  output logic [8:0] byte_idx,
  output logic byte_strobe,
  output logic frame_done
);
  logic [8:0] cnt_reg;
  logic [7:0] inst_reg;
  logic [8:0] len_reg;
  logic [7:0] st_reg, cnt_h_reg, flg_reg, lo_reg;
  logic [8:0] rlen_reg;
  logic [7:0] d_reg;
  logic [8:0] i_reg;
  logic stb_reg, done_reg;

  wire logic fire = link.valid & link.ready;
  wire logic frag = link.inst == rrif_pkg::INST_FRAG;
  wire logic [8:0] pos = link.sof ? 9'h000 : cnt_reg;
  wire logic [8:0] off = frag ? 9'h004 : 9'h000;
  assign link.ready = accept;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_reg <= 9'h000;
      inst_reg <= 8'h00;
      len_reg <= 9'h000;
      st_reg <= 8'h00;
      cnt_h_reg <= 8'h00;
      flg_reg <= 8'h00;
      lo_reg <= 8'h00;
      rlen_reg <= 9'h000;
      d_reg <= 8'h00;
      i_reg <= 9'h000;
      stb_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      stb_reg <= fire;
      done_reg <= fire & link.last;
      if (fire) begin
        cnt_reg <= link.last ? 9'h000 : pos + 9'h001;
        d_reg <= link.data;
        i_reg <= pos;
        if (pos == 9'h000) st_reg <= link.data;
        if (pos == off + 9'h001) cnt_h_reg <= link.data;
        if (pos == off + 9'h002) flg_reg <= link.data;
        if (pos == off + 9'h003) lo_reg <= link.data;
        if (pos == off + 9'h004) rlen_reg <= {link.data[0], lo_reg};
        if (link.last) begin
          inst_reg <= link.inst;
          len_reg <= pos + 9'h001;
        end
      end
    end
  end
  assign frame_inst = inst_reg;
  assign frame_len = len_reg;
  assign hdr_status = st_reg;
  assign hdr_count = cnt_h_reg;
  assign hdr_flags = flg_reg;
  assign res_len = rlen_reg;
  assign byte_data = d_reg;
  assign byte_idx = i_reg;
  assign byte_strobe = stb_reg;
  assign frame_done = done_reg;
endmodule
`default_nettype wire

// ==== src/rrif_reader_end.sv ====
`default_nettype none
module rrif_reader_end (
  input wire logic ref_clk,
  input wire logic resetn,
  rrif_link_if.dev link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  typedef enum logic [1:0] {RRIF_IDLE = 2'b00, RRIF_SEND = 2'b01, RRIF_GAP = 2'b10} rrif_st_t;
  rrif_st_t st_reg;
  logic [31:0] ctrl_reg;
  logic [8:0] len_reg;
  logic [31:0] hdr_reg;
  logic [23:0] frag_reg;
  logic [7:0] mem [0:rrif_pkg::PAYLOAD_DEPTH-1];
  logic [7:0] wptr_reg;
  logic [8:0] idx_reg;
  logic [rrif_pkg::EV_W-1:0] stat_reg;
  logic [rrif_pkg::EV_W-1:0] mask_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic sent_reg;
  logic [8:0] flen_reg;
  logic fmode_reg;

  wire logic enable = ctrl_reg[0];
  wire logic frag_mode = ctrl_reg[1];
  // Frame in flight uses length and format frozen at its start
  wire logic [8:0] hdr_len = fmode_reg ? rrif_pkg::FRAG_HDR : rrif_pkg::PLAIN_HDR;
  wire logic [8:0] len_max = frag_mode ? rrif_pkg::FRAG_LEN_MAX : rrif_pkg::PLAIN_LEN_MAX;
  wire logic len_ok = (len_reg >= rrif_pkg::LEN_MIN) && (len_reg <= len_max);
  wire logic [8:0] pay_len = (flen_reg > hdr_len) ? flen_reg - hdr_len : 9'h000;
  wire logic req = (avs_read | avs_write) & ~ack_reg;
  // Write lands at the edge where waitrequest is low
  wire logic wr = avs_write & ack_reg;
  wire logic rd = avs_read & ~ack_reg;
  wire logic [8:0] pidx = idx_reg - hdr_len;
  wire logic [7:0] pbyte = mem[pidx[7:0]];
  wire logic stat_rd = rd && avs_address == rrif_pkg::REG_IRQ;
  wire logic fire = link.valid & link.ready;

  // Header byte selection per format
  logic [7:0] cur_byte;
  always_comb begin
    cur_byte = pbyte;
    if (!fmode_reg) begin
      case (idx_reg)
        9'h000: cur_byte = hdr_reg[7:0];
        9'h001: cur_byte = hdr_reg[15:8];
        9'h002: cur_byte = {2'b00, hdr_reg[21:16]};
        9'h003: cur_byte = pay_len[7:0];
        9'h004: cur_byte = {7'h00, pay_len[8]};
        default: cur_byte = pbyte;
      endcase
    end else begin
      case (idx_reg)
        9'h000: cur_byte = hdr_reg[7:0];
        9'h001: cur_byte = {1'b0, hdr_reg[26:24], 2'b00, hdr_reg[29:28]};
        9'h002: cur_byte = frag_reg[7:0];
        9'h003: cur_byte = frag_reg[15:8];
        9'h004: cur_byte = frag_reg[23:16];
        9'h005: cur_byte = hdr_reg[15:8];
        9'h006: cur_byte = {2'b00, hdr_reg[21:16]};
        9'h007: cur_byte = pay_len[7:0];
        9'h008: cur_byte = {7'h00, pay_len[8]};
        default: cur_byte = pbyte;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign irq = |(stat_reg & mask_reg);
  assign link.valid = (st_reg == RRIF_SEND);
  assign link.sof = link.valid && idx_reg == 9'h000;
  assign link.last = link.valid && idx_reg == flen_reg - 9'h001;
  assign link.data = cur_byte;
  assign link.inst = fmode_reg ? rrif_pkg::INST_FRAG : rrif_pkg::INST_PLAIN;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_reg <= rrif_pkg::CTRL_RESET;
      len_reg <= 9'h000;
      hdr_reg <= 32'h0000_0000;
      frag_reg <= 24'h00_0000;
      wptr_reg <= 8'h00;
      mask_reg <= '0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (wr) begin
        case (avs_address)
          rrif_pkg::REG_CTRL: ctrl_reg <= avs_writedata;
          rrif_pkg::REG_LEN: len_reg <= avs_writedata[8:0];
          rrif_pkg::REG_HDR: hdr_reg <= avs_writedata;
          rrif_pkg::REG_FRAG: frag_reg <= avs_writedata[23:0];
          rrif_pkg::REG_DATA: begin
            mem[wptr_reg] <= avs_writedata[7:0];
            wptr_reg <= (wptr_reg == 8'hFE) ? 8'h00 : wptr_reg + 8'h01;
          end
          rrif_pkg::REG_MASK: mask_reg <= avs_writedata[rrif_pkg::EV_W-1:0];
          default: ;
        endcase
        if (avs_address == rrif_pkg::REG_CTRL && avs_writedata[8])
          wptr_reg <= 8'h00;
      end
      if (rd) begin
        case (avs_address)
          rrif_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
          rrif_pkg::REG_LEN: rdata_reg <= {23'h0, len_reg};
          rrif_pkg::REG_HDR: rdata_reg <= hdr_reg;
          rrif_pkg::REG_FRAG: rdata_reg <= {8'h00, frag_reg};
          rrif_pkg::REG_STAT: rdata_reg <= {20'h0, 2'(st_reg), len_ok, idx_reg};
          rrif_pkg::REG_IRQ: rdata_reg <= {29'h0, stat_reg};
          rrif_pkg::REG_MASK: rdata_reg <= {29'h0, mask_reg};
          default: rdata_reg <= rrif_pkg::RDATA_BAD;
        endcase
      end
    end
  end
  assign avs_readdata = rdata_reg;

  // Cyclic frame sequencer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= RRIF_IDLE;
      idx_reg <= 9'h000;
      sent_reg <= 1'b0;
      stat_reg <= '0;
      flen_reg <= 9'h000;
      fmode_reg <= 1'b0;
    end else begin
      sent_reg <= 1'b0;
      case (st_reg)
        RRIF_IDLE: begin
          flen_reg <= len_reg;
          fmode_reg <= frag_mode;
          if (enable && len_ok) st_reg <= RRIF_SEND;
        end
        RRIF_SEND: if (fire) begin
          if (link.last) begin
            idx_reg <= 9'h000;
            st_reg <= RRIF_GAP;
            sent_reg <= 1'b1;
          end else begin
            idx_reg <= idx_reg + 9'h001;
          end
        end
        RRIF_GAP: st_reg <= RRIF_IDLE;
        default: st_reg <= RRIF_IDLE;
      endcase
      // Set wins over read-clear
      stat_reg <= (stat_rd ? '0 : stat_reg)
        | {1'b0, enable & ~len_ok, sent_reg};
    end
  end
endmodule
`default_nettype wire
